// ===== hw/charger_cfg_pkg.sv
// constants, field layout and decode helpers of the charger config registers
// assumes values in mA and mV fit 12 bits
package charger_cfg_pkg;

  // =====================================================================
  // serial addressing
  localparam logic [7:0] DEV_ADDR_W  = 8'hd6;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_BIT    = 4'h7;
  localparam logic [3:0] ACK_END     = 4'h9;

  // =====================================================================
  // register offsets
  localparam logic [7:0] OFS_MODE     = 8'h01;
  localparam logic [7:0] OFS_BOOST    = 8'h02;
  localparam logic [7:0] OFS_PRE_TERM = 8'h03;

  // =====================================================================
  // field positions
  localparam int B_PFM   = 7;
  localparam int B_KICK  = 6;
  localparam int B_OTG   = 5;
  localparam int B_CHG   = 4;
  localparam int B_SYS   = 1;
  localparam int B_VBSEL = 0;
  localparam int B_BLIM  = 7;
  localparam int B_Q1    = 6;
  localparam int B_FAST_CHARGE_CURRENT  = 0;
  localparam int B_IPRE  = 4;
  localparam int B_TERMINATION_CURRENT = 0;

  // =====================================================================
  // reset values
  localparam logic       DEF_PFM   = 1'b0;
  localparam logic       DEF_KICK  = 1'b0;
  localparam logic       DEF_OTG   = 1'b0;
  localparam logic       DEF_CHG   = 1'b1;
  localparam logic [2:0] DEF_SYS   = 3'h5;
  localparam logic       DEF_VBSEL = 1'b0;
  localparam logic       DEF_BLIM  = 1'b1;
  localparam logic       DEF_Q1    = 1'b0;
  localparam logic [5:0] DEF_FAST_CHARGE_CURRENT  = 6'h22;
  localparam logic [3:0] DEF_IPRE  = 4'h2;
  localparam logic [3:0] DEF_TERMINATION_CURRENT = 4'h2;

  // =====================================================================
  // limits and analog values
  localparam logic [5:0]  FAST_CHARGE_CURRENT_MAX    = 6'h32;
  localparam logic [3:0]  IPRE_MAX    = 4'hc;
  localparam logic [4:0]  ILIM_700MA  = 5'h06;
  localparam logic [11:0] STEP_MA     = 12'h03c;
  localparam logic [11:0] ZERO_MA     = 12'h000;
  localparam logic [11:0] BOOST_LO_MA = 12'h1f4;
  localparam logic [11:0] BOOST_HI_MA = 12'h4b0;
  localparam logic [11:0] VBAT_28_MV  = 12'haf0;
  localparam logic [11:0] VBAT_25_MV  = 12'h9c4;
  localparam logic [11:0] VBAT_30_MV  = 12'hbb8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_PTR  = 3'b010,
    ST_WR   = 3'b011,
    ST_RD   = 3'b100
  } port_st_t;

  function automatic logic [11:0] sys_floor_mv_of(input logic [2:0] code);
    case (code)
      3'h0: sys_floor_mv_of = 12'ha28;
      3'h1: sys_floor_mv_of = 12'haf0;
      3'h2: sys_floor_mv_of = 12'hbb8;
      3'h3: sys_floor_mv_of = 12'hc80;
      3'h4: sys_floor_mv_of = 12'hd48;
      3'h5: sys_floor_mv_of = 12'hdac;
      3'h6: sys_floor_mv_of = 12'he10;
      default: sys_floor_mv_of = 12'he74;
    endcase
  endfunction

  // offset plus binary weights, bit k worth 2^k steps
  function automatic logic [11:0] current_ma_of(input logic [5:0] code,
                                                input logic [11:0] ofs);
    current_ma_of = 12'(ofs + 12'(12'(code) * STEP_MA));
  endfunction

endpackage

// ===== hw/charger_cfg_regs.sv
// config registers 1 to 3 of a single-cell charger, with serial slave
// assumes serial pins and control inputs synchronous to clk
//
// Summary of operation
// R1: writing 1 to the kick bit pulses the watchdog restart, and the bit clears itself.
// R2: reverse boost enabled suppresses charging whatever the charge bit holds.
// R3: charging runs only with the charge pin low and the charge bit set together.
// R4: the 3-bit system floor code picks 2.6 to 3.7 V, default code 101 (3.5 V).
// R5: the battery floor bit picks 2.8 V falling (3.0 V rising) or 2.5 V, default 0.
// R6: the boost limit bit picks 0.5 A or 1.2 A, default 1.2 A.
// R7: with the FET bit 0 the high-resistance FET is used below a 700 mA input limit.
// R8: in boost mode the full input FET is used whatever the FET bit holds.
// R9: fast charge current is 60 mA per code step, no offset, default 100010.
// R10: fast charge code zero stops charging; codes above 110010 clamp to 3000 mA.
// R11: precharge and termination are 60 mA plus 60 mA steps, default 0010; precharge clamps at 1100.
// R12: register reset restores all fields; watchdog expiry restores all but four.
// R13: the host reaches the registers at serial address d6, read with bit 0 set.
`timescale 1ns/100ps
module charger_cfg_regs #(
  parameter logic [7:0] DEV_ADDR = charger_cfg_pkg::DEV_ADDR_W
) (
  // system
  input  wire logic       clk,
  input  wire logic       rst_b,
  // serial pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // charger side
  input  wire logic       charge_enable_pin_b,
  input  wire logic       wd_expire,
  input  wire logic       reg_reset,
  input  wire logic [4:0] input_current_limit,
  // settings out
  output logic            host_timer_kick,
  output logic            charge_en,
  output logic            boost_en,
  output logic            light_load_pulse_skip_disable,
  output logic [11:0]     system_floor_mv,
  output logic [11:0]     batt_floor_fall_mv,
  output logic [11:0]     batt_floor_rise_mv,
  output logic [11:0]     boost_limit_ma,
  output logic            input_fet_low_resistance,
  output logic [11:0]     fast_charge_ma,
  output logic [11:0]     precharge_ma,
  output logic [11:0]     termination_ma
);

  // =====================================================================
  // serial slave
  logic       wr_stb;
  logic [7:0] reg_ptr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic       oe_w;

  serial_reg_port #(
    .DEV_ADDR (DEV_ADDR)
  ) u_port (
    .clk     (clk),
    .rst_b   (rst_b),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_oe  (oe_w),
    .wr_stb  (wr_stb),
    .reg_ptr (reg_ptr),
    .wr_data (wr_data),
    .rd_data (rd_data)
  );

  // =====================================================================
  // register fields
  logic       pfm_r, pfm_nxt;
  logic       kick_r, kick_nxt;
  logic       otg_r, otg_nxt;
  logic       chg_r, chg_nxt;
  logic [2:0] sys_r, sys_nxt;
  logic       vbsel_r, vbsel_nxt;
  logic       blim_r, blim_nxt;
  logic       q1_r, q1_nxt;
  logic [5:0] fast_charge_current_r, fast_charge_current_nxt;
  logic [3:0] ipre_r, ipre_nxt;
  logic [3:0] termination_current_r, termination_current_nxt;
  logic       wr_mode;
  logic       wr_boost;
  logic       wr_pt;

  assign wr_mode  = wr_stb && reg_ptr == charger_cfg_pkg::OFS_MODE;
  assign wr_boost = wr_stb && reg_ptr == charger_cfg_pkg::OFS_BOOST;
  assign wr_pt    = wr_stb && reg_ptr == charger_cfg_pkg::OFS_PRE_TERM;

  // unmapped offsets read zero and ignore writes
  always_comb begin
    case (reg_ptr)
      charger_cfg_pkg::OFS_MODE:
        rd_data = {pfm_r, kick_r, otg_r, chg_r, sys_r, vbsel_r};
      charger_cfg_pkg::OFS_BOOST:
        rd_data = {blim_r, q1_r, fast_charge_current_r};
      charger_cfg_pkg::OFS_PRE_TERM:
        rd_data = {ipre_r, termination_current_r};
      default:
        rd_data = 8'h00;
    endcase
  end

  always_comb begin
    pfm_nxt   = pfm_r;
    kick_nxt  = charger_cfg_pkg::DEF_KICK; // R1
    otg_nxt   = otg_r;
    chg_nxt   = chg_r;
    sys_nxt   = sys_r;
    vbsel_nxt = vbsel_r;
    blim_nxt  = blim_r;
    q1_nxt    = q1_r;
    fast_charge_current_nxt  = fast_charge_current_r;
    ipre_nxt  = ipre_r;
    termination_current_nxt = termination_current_r;
    if (reg_reset) begin // R12
      pfm_nxt   = charger_cfg_pkg::DEF_PFM;
      otg_nxt   = charger_cfg_pkg::DEF_OTG;
      chg_nxt   = charger_cfg_pkg::DEF_CHG;
      sys_nxt   = charger_cfg_pkg::DEF_SYS;
      vbsel_nxt = charger_cfg_pkg::DEF_VBSEL;
      blim_nxt  = charger_cfg_pkg::DEF_BLIM;
      q1_nxt    = charger_cfg_pkg::DEF_Q1;
      fast_charge_current_nxt  = charger_cfg_pkg::DEF_FAST_CHARGE_CURRENT;
      ipre_nxt  = charger_cfg_pkg::DEF_IPRE;
      termination_current_nxt = charger_cfg_pkg::DEF_TERMINATION_CURRENT;
    end else if (wd_expire) begin
      // light-load, floors and FET choice survive expiry
      otg_nxt   = charger_cfg_pkg::DEF_OTG; // R12
      chg_nxt   = charger_cfg_pkg::DEF_CHG;
      blim_nxt  = charger_cfg_pkg::DEF_BLIM;
      fast_charge_current_nxt  = charger_cfg_pkg::DEF_FAST_CHARGE_CURRENT;
      ipre_nxt  = charger_cfg_pkg::DEF_IPRE;
      termination_current_nxt = charger_cfg_pkg::DEF_TERMINATION_CURRENT;
    end else begin
      if (wr_mode) begin
        pfm_nxt   = wr_data[charger_cfg_pkg::B_PFM];
        kick_nxt  = wr_data[charger_cfg_pkg::B_KICK]; // R1
        otg_nxt   = wr_data[charger_cfg_pkg::B_OTG];
        chg_nxt   = wr_data[charger_cfg_pkg::B_CHG];
        sys_nxt   = wr_data[charger_cfg_pkg::B_SYS +: 3];
        vbsel_nxt = wr_data[charger_cfg_pkg::B_VBSEL];
      end
      if (wr_boost) begin
        blim_nxt = wr_data[charger_cfg_pkg::B_BLIM];
        q1_nxt   = wr_data[charger_cfg_pkg::B_Q1];
        fast_charge_current_nxt = wr_data[charger_cfg_pkg::B_FAST_CHARGE_CURRENT +: 6];
      end
      if (wr_pt) begin
        ipre_nxt  = wr_data[charger_cfg_pkg::B_IPRE +: 4];
        termination_current_nxt = wr_data[charger_cfg_pkg::B_TERMINATION_CURRENT +: 4];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pfm_r   <= charger_cfg_pkg::DEF_PFM;
      kick_r  <= charger_cfg_pkg::DEF_KICK;
      otg_r   <= charger_cfg_pkg::DEF_OTG;
      chg_r   <= charger_cfg_pkg::DEF_CHG;
      sys_r   <= charger_cfg_pkg::DEF_SYS;
      vbsel_r <= charger_cfg_pkg::DEF_VBSEL;
      blim_r  <= charger_cfg_pkg::DEF_BLIM;
      q1_r    <= charger_cfg_pkg::DEF_Q1;
      fast_charge_current_r  <= charger_cfg_pkg::DEF_FAST_CHARGE_CURRENT;
      ipre_r  <= charger_cfg_pkg::DEF_IPRE;
      termination_current_r <= charger_cfg_pkg::DEF_TERMINATION_CURRENT;
    end else begin
      pfm_r   <= pfm_nxt;
      kick_r  <= kick_nxt;
      otg_r   <= otg_nxt;
      chg_r   <= chg_nxt;
      sys_r   <= sys_nxt;
      vbsel_r <= vbsel_nxt;
      blim_r  <= blim_nxt;
      q1_r    <= q1_nxt;
      fast_charge_current_r  <= fast_charge_current_nxt;
      ipre_r  <= ipre_nxt;
      termination_current_r <= termination_current_nxt;
    end
  end

  // =====================================================================
  // derived settings, one cycle behind the fields
  logic [5:0]  fast_charge_current_eff;
  logic [3:0]  ipre_eff;
  logic        chg_en_nxt;
  logic        fet_nxt;
  logic [11:0] sysmv_nxt;
  logic [11:0] vbf_nxt;
  logic [11:0] blim_ma_nxt;
  logic [11:0] fast_nxt;
  logic [11:0] pre_nxt;
  logic [11:0] term_nxt;
  logic        chg_en_r;
  logic        fet_r;
  logic [11:0] sysmv_r;
  logic [11:0] vbf_r;
  logic [11:0] blim_ma_r;
  logic [11:0] fast_r;
  logic [11:0] pre_r;
  logic [11:0] term_r;
  logic        oe_r;

  always_comb begin
    fast_charge_current_eff = (fast_charge_current_r > charger_cfg_pkg::FAST_CHARGE_CURRENT_MAX) ?
               charger_cfg_pkg::FAST_CHARGE_CURRENT_MAX : fast_charge_current_r; // R10
    ipre_eff = (ipre_r > charger_cfg_pkg::IPRE_MAX) ?
               charger_cfg_pkg::IPRE_MAX : ipre_r; // R11
    // boost wins over the charge bit; code zero also stops charge
    chg_en_nxt = chg_r && !charge_enable_pin_b // R3
                 && !otg_r // R2
                 && fast_charge_current_r != 6'h00; // R10
    // boost forces the full FET; low limits need the accurate one
    fet_nxt = otg_r // R8
              || q1_r
              || input_current_limit >= charger_cfg_pkg::ILIM_700MA; // R7
    sysmv_nxt = charger_cfg_pkg::sys_floor_mv_of(sys_r); // R4
    vbf_nxt = vbsel_r ? charger_cfg_pkg::VBAT_25_MV
                      : charger_cfg_pkg::VBAT_28_MV; // R5
    blim_ma_nxt = blim_r ? charger_cfg_pkg::BOOST_HI_MA
                         : charger_cfg_pkg::BOOST_LO_MA; // R6
    fast_nxt = charger_cfg_pkg::current_ma_of(fast_charge_current_eff,
                                              charger_cfg_pkg::ZERO_MA); // R9
    pre_nxt = charger_cfg_pkg::current_ma_of({2'b00, ipre_eff},
                                             charger_cfg_pkg::STEP_MA); // R11
    term_nxt = charger_cfg_pkg::current_ma_of({2'b00, termination_current_r},
                                              charger_cfg_pkg::STEP_MA); // R11
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chg_en_r  <= 1'b0;
      fet_r     <= 1'b0;
      sysmv_r   <= 12'h000;
      vbf_r     <= 12'h000;
      blim_ma_r <= 12'h000;
      fast_r    <= 12'h000;
      pre_r     <= 12'h000;
      term_r    <= 12'h000;
      oe_r      <= 1'b0;
    end else begin
      chg_en_r  <= chg_en_nxt;
      fet_r     <= fet_nxt;
      sysmv_r   <= sysmv_nxt;
      vbf_r     <= vbf_nxt;
      blim_ma_r <= blim_ma_nxt;
      fast_r    <= fast_nxt;
      pre_r     <= pre_nxt;
      term_r    <= term_nxt;
      oe_r      <= oe_w;
    end
  end

  // open drain: data level is always low, the enable does the work
  assign sda_out                       = 1'b0;
  assign sda_oe                        = oe_r;
  assign host_timer_kick               = kick_r;
  assign charge_en                     = chg_en_r;
  assign boost_en                      = otg_r;
  assign light_load_pulse_skip_disable = pfm_r;
  assign system_floor_mv               = sysmv_r;
  assign batt_floor_fall_mv            = vbf_r;
  assign batt_floor_rise_mv            = charger_cfg_pkg::VBAT_30_MV;
  assign boost_limit_ma                = blim_ma_r;
  assign input_fet_low_resistance      = fet_r;
  assign fast_charge_ma                = fast_r;
  assign precharge_ma                  = pre_r;
  assign termination_ma                = term_r;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_kick_self_clear: assert property (kick_r |=> !kick_r) // R1
    else $error("kick bit did not clear");
  a_kick_from_write: assert property (
    wr_mode && !reg_reset && !wd_expire && wr_data[charger_cfg_pkg::B_KICK]
    |=> host_timer_kick ##1 !host_timer_kick) // R1
    else $error("kick write gave no single pulse");
  a_boost_blocks_chg: assert property (otg_r |=> !charge_en) // R2
    else $error("charging while boost enabled");
  a_charge_needs_both: assert property (
    charge_en |-> $past(chg_r) && $past(charge_enable_pin_b) == 1'b0) // R3
    else $error("charging without pin and bit");
  a_floor_default: assert property (
    rst_b && sys_r == charger_cfg_pkg::DEF_SYS |=> system_floor_mv == 12'hdac) // R4
    else $error("system floor default wrong");
  a_batt_floor: assert property (
    vbsel_r |=> batt_floor_fall_mv == charger_cfg_pkg::VBAT_25_MV) // R5
    else $error("battery floor select wrong");
  a_boost_limit: assert property (
    !blim_r |=> boost_limit_ma == charger_cfg_pkg::BOOST_LO_MA) // R6
    else $error("boost limit select wrong");
  a_fet_accurate: assert property (
    !otg_r && !q1_r && input_current_limit < charger_cfg_pkg::ILIM_700MA
    |=> !input_fet_low_resistance) // R7
    else $error("low FET used under small limit");
  a_boost_full_fet: assert property (otg_r |=> input_fet_low_resistance) // R8
    else $error("boost without full FET");
  a_fast_charge_current_weight: assert property (
    rst_b && fast_charge_current_r <= charger_cfg_pkg::FAST_CHARGE_CURRENT_MAX
    |=> fast_charge_ma == 12'($past(fast_charge_current_r) * charger_cfg_pkg::STEP_MA)) // R9
    else $error("fast charge weight wrong");
  a_fast_charge_current_clamp: assert property (
    fast_charge_current_r > charger_cfg_pkg::FAST_CHARGE_CURRENT_MAX |=> fast_charge_ma == 12'hbb8) // R10
    else $error("fast charge clamp wrong");
  a_fast_charge_current_zero_off: assert property (fast_charge_current_r == 6'h00 |=> !charge_en) // R10
    else $error("charging with zero current code");
  a_pre_clamp: assert property (
    ipre_r > charger_cfg_pkg::IPRE_MAX |=> precharge_ma == 12'h30c) // R11
    else $error("precharge clamp wrong");
  a_wd_keeps_floor: assert property (
    wd_expire && !reg_reset |=> $stable(sys_r) && $stable(q1_r)
    && fast_charge_current_r == charger_cfg_pkg::DEF_FAST_CHARGE_CURRENT) // R12
    else $error("watchdog restore wrong");

  c_kick_write: cover property (wr_mode && wr_data[charger_cfg_pkg::B_KICK]);
  c_charge_on: cover property (!charge_en ##1 charge_en);
  c_boost_on: cover property (!boost_en ##1 boost_en);
  c_wd_expire: cover property (wd_expire && !reg_reset);

endmodule // charger_cfg_regs

// ===== hw/serial_reg_port.sv
// two-wire serial slave giving byte access to a register pointer
// assumes scl and sda are already synchronous and much slower than clk
`timescale 1ns/100ps
module serial_reg_port #(
  parameter logic [7:0] DEV_ADDR = charger_cfg_pkg::DEV_ADDR_W
) (
  // system
  input  wire logic       clk,
  input  wire logic       rst_b,
  // serial pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe,
  // register side
  output logic            wr_stb,
  output logic [7:0]      reg_ptr,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data
);

  if (DEV_ADDR[0] != 1'b0) begin : g_addr_chk
    $error("device address must be even");
  end

  // =====================================================================
  // line events
  logic scl_q_r;
  logic sda_q_r;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  assign start = scl_q_r & scl_in & sda_q_r & ~sda_in;
  assign stop  = scl_q_r & scl_in & ~sda_q_r & sda_in;
  assign rise  = scl_in & ~scl_q_r;
  assign fall  = ~scl_in & scl_q_r;

  // =====================================================================
  // byte engine
  charger_cfg_pkg::port_st_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic       rw_r, rw_nxt;
  logic       oe_r, oe_nxt;
  logic       wr_r, wr_nxt;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    sh_nxt  = sh_r;
    ptr_nxt = ptr_r;
    wd_nxt  = wd_r;
    rw_nxt  = rw_r;
    oe_nxt  = oe_r;
    wr_nxt  = 1'b0;
    if (start) begin
      st_nxt  = charger_cfg_pkg::ST_DEV;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end else if (stop) begin
      st_nxt = charger_cfg_pkg::ST_IDLE;
      oe_nxt = 1'b0;
    end else if (rise) begin
      if (st_r == charger_cfg_pkg::ST_RD) begin
        // master ack slot: nack ends the read
        if (cnt_r == charger_cfg_pkg::BYTE_BITS) begin
          if (sda_in) begin
            st_nxt = charger_cfg_pkg::ST_IDLE;
          end else begin
            ptr_nxt = 8'(ptr_r + 8'h01);
            cnt_nxt = charger_cfg_pkg::ACK_END;
          end
        end
      end else if (st_r != charger_cfg_pkg::ST_IDLE &&
                   cnt_r < charger_cfg_pkg::BYTE_BITS) begin
        sh_nxt  = {sh_r[6:0], sda_in};
        cnt_nxt = 4'(cnt_r + 4'h1);
      end
    end else if (fall && st_r != charger_cfg_pkg::ST_IDLE) begin
      if (cnt_r == charger_cfg_pkg::ACK_END &&
          (st_r == charger_cfg_pkg::ST_RD || (st_r == charger_cfg_pkg::ST_DEV && rw_r))) begin
        // open drain: drive low for a zero bit
        st_nxt  = charger_cfg_pkg::ST_RD;
        sh_nxt  = rd_data;
        oe_nxt  = ~rd_data[7];
        cnt_nxt = 4'h0;
      end else if (st_r == charger_cfg_pkg::ST_RD) begin
        if (cnt_r < charger_cfg_pkg::LAST_BIT) begin
          sh_nxt  = {sh_r[6:0], 1'b0};
          oe_nxt  = ~sh_r[6];
          cnt_nxt = 4'(cnt_r + 4'h1);
        end else if (cnt_r == charger_cfg_pkg::LAST_BIT) begin
          oe_nxt  = 1'b0;
          cnt_nxt = charger_cfg_pkg::BYTE_BITS;
        end
      end else if (cnt_r == charger_cfg_pkg::BYTE_BITS) begin
        cnt_nxt = charger_cfg_pkg::ACK_END;
        oe_nxt  = 1'b1;
        case (st_r)
          charger_cfg_pkg::ST_DEV: begin
            if (sh_r[7:1] == DEV_ADDR[7:1]) begin // R13
              rw_nxt = sh_r[0];
            end else begin
              st_nxt = charger_cfg_pkg::ST_IDLE;
              oe_nxt = 1'b0;
            end
          end
          charger_cfg_pkg::ST_PTR: ptr_nxt = sh_r;
          default: begin
            wd_nxt = sh_r;
            wr_nxt = 1'b1;
          end
        endcase
      end else if (cnt_r == charger_cfg_pkg::ACK_END) begin
        oe_nxt  = 1'b0;
        cnt_nxt = 4'h0;
        if (st_r == charger_cfg_pkg::ST_DEV) begin
          st_nxt = charger_cfg_pkg::ST_PTR;
        end else if (st_r == charger_cfg_pkg::ST_PTR) begin
          st_nxt = charger_cfg_pkg::ST_WR;
        end else begin
          ptr_nxt = 8'(ptr_r + 8'h01);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      st_r    <= charger_cfg_pkg::ST_IDLE;
      cnt_r   <= 4'h0;
      sh_r    <= 8'h00;
      ptr_r   <= 8'h00;
      wd_r    <= 8'h00;
      rw_r    <= 1'b0;
      oe_r    <= 1'b0;
      wr_r    <= 1'b0;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      ptr_r   <= ptr_nxt;
      wd_r    <= wd_nxt;
      rw_r    <= rw_nxt;
      oe_r    <= oe_nxt;
      wr_r    <= wr_nxt;
    end
  end

  assign sda_oe  = oe_r;
  assign wr_stb  = wr_r;
  assign reg_ptr = ptr_r;
  assign wr_data = wd_r;

endmodule // serial_reg_port

// ===== verif/host_master.sv
// host side serial master model for the charger config registers
// assumes the bench resolves the open-drain data wire with a pull-up
`timescale 1ns/100ps
module host_master (
  // system
  input  wire logic clk,
  // serial pins
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // =========================================
  // bit timing
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // four clocks a level, above the slave's two-sample need
  task automatic hold();
    repeat (4) @(posedge clk);
  endtask
  // b = 1 releases the wire; sampled halfway through the high phase
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    hold();
    sda_pull <= ~b;
    hold();
    scl <= 1'b1;
    hold();
    s = sda;
    hold();
  endtask
  // =========================================
  // framing
  task automatic start();
    scl <= 1'b0;
    hold();
    sda_pull <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_pull <= 1'b1;
    hold();
  endtask
  task automatic stop();
    scl <= 1'b0;
    hold();
    sda_pull <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_pull <= 1'b0;
    hold();
  endtask
  // msb first, ninth slot sends last and returns the wire level
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic s9);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, s9);
  endtask
endmodule // host_master

// ===== verif/tb_top.sv
// self-checking bench for the charger config registers
// assumes host_master as the serial host and a pulled-up data wire
`timescale 1ns/100ps
module tb_top;
  // =========================================
  // signals
  logic        clk, rst_b, scl_in, sda_in, sda_oe, sda_pull, sda_od;
  logic        charge_enable_pin_b, wd_expire, reg_reset;
  logic [4:0]  input_current_limit;
  logic        host_timer_kick, charge_en, boost_en, pfm_off, fet_lo;
  logic [11:0] sys_mv, fall_mv, rise_mv, blim_ma, fast_ma, pre_ma, term_ma;
  int          fail_count = 0;
  int          check_count = 0;
  int          kicks = 0;
  // open drain wire: device level only counts while enabled, pull-up otherwise
  assign sda_in = (sda_oe ? sda_od : 1'b1) & ~sda_pull;
  initial clk = 1'b0;
  always #50 clk = ~clk;
  always @(posedge clk) if (host_timer_kick === 1'b1) kicks <= kicks + 1;
  host_master hm (.clk(clk), .scl(scl_in), .sda_pull(sda_pull), .sda(sda_in));
  charger_cfg_regs dut (
    .clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_od), .sda_oe(sda_oe), .charge_enable_pin_b(charge_enable_pin_b),
    .wd_expire(wd_expire), .reg_reset(reg_reset),
    .input_current_limit(input_current_limit),
    .host_timer_kick(host_timer_kick), .charge_en(charge_en),
    .boost_en(boost_en), .light_load_pulse_skip_disable(pfm_off),
    .system_floor_mv(sys_mv), .batt_floor_fall_mv(fall_mv),
    .batt_floor_rise_mv(rise_mv), .boost_limit_ma(blim_ma),
    .input_fet_low_resistance(fet_lo), .fast_charge_ma(fast_ma),
    .precharge_ma(pre_ma), .termination_ma(term_ma));
  // =========================================
  // tasks
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    logic       s;
    hm.start();
    hm.xfer(charger_cfg_pkg::DEV_ADDR_W, 1'b1, q, s);
    hm.xfer(p, 1'b1, q, s);
    hm.xfer(d, 1'b1, q, s);
    chk({11'h0, s}, 12'h000);
    hm.stop();
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] q;
    logic       s;
    hm.start();
    hm.xfer(charger_cfg_pkg::DEV_ADDR_W, 1'b1, q, s);
    hm.xfer(p, 1'b1, q, s);
    hm.start();
    hm.xfer(charger_cfg_pkg::DEV_ADDR_W | 8'h01, 1'b1, q, s);
    hm.xfer(8'hff, 1'b1, q, s);
    hm.stop();
    chk({4'h0, q}, {4'h0, e});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // =========================================
  // timeout, far above the longest sequence
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  // =========================================
  // sequence
  initial begin
    logic [7:0] q;
    logic       s;
    rst_b = 1'b0;
    charge_enable_pin_b = 1'b0;
    wd_expire = 1'b0;
    reg_reset = 1'b0;
    input_current_limit = 5'h05;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk(sys_mv, 12'hdac);
    chk(fast_ma, 12'h7f8);
    chk(pre_ma, 12'h0b4);
    chk(term_ma, 12'h0b4);
    chk(blim_ma, 12'h4b0);
    chk(fall_mv, 12'haf0);
    chk(rise_mv, 12'hbb8);
    chk({10'h0, charge_en, fet_lo}, 12'h002);
    rd(8'h01, 8'h1a);
    rd(8'h02, 8'ha2);
    rd(8'h03, 8'h22);
    wr(8'h02, 8'h7f);
    chk(fast_ma, 12'hbb8);
    chk({blim_ma[11:1], fet_lo}, 12'h1f5);
    wr(8'h02, 8'h01);
    chk({fast_ma[11:1], fet_lo}, 12'h03c);
    input_current_limit <= 5'h06;
    repeat (3) @(posedge clk);
    chk({11'h0, fet_lo}, 12'h001);
    input_current_limit <= 5'h05;
    wr(8'h02, 8'h00);
    chk({11'h0, charge_en}, 12'h000);
    wr(8'h02, 8'ha2);
    wr(8'h01, 8'h3b);
    chk({9'h0, boost_en, charge_en, fet_lo}, 12'h005);
    chk(fall_mv, 12'h9c4);
    wr(8'h01, 8'h5a);
    chk(12'(kicks), 12'h001);
    rd(8'h01, 8'h1a);
    charge_enable_pin_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk({11'h0, charge_en}, 12'h000);
    charge_enable_pin_b <= 1'b0;
    wr(8'h03, 8'hff);
    chk(pre_ma, 12'h30c);
    chk(term_ma, 12'h3c0);
    wr(8'h01, 8'h8f);
    wr(8'h02, 8'h40);
    wd_expire <= 1'b1;
    @(posedge clk);
    wd_expire <= 1'b0;
    rd(8'h01, 8'h9f);
    rd(8'h02, 8'he2);
    rd(8'h03, 8'h22);
    chk({sys_mv[11:1], pfm_off}, 12'he75);
    reg_reset <= 1'b1;
    @(posedge clk);
    reg_reset <= 1'b0;
    rd(8'h01, 8'h1a);
    rd(8'h02, 8'ha2);
    hm.start();
    hm.xfer(8'h50, 1'b1, q, s);
    hm.stop();
    chk({11'h0, s}, 12'h001);
    end_sim();
  end
endmodule // tb_top
